// ---- rtl/fpc_fetch_pc.sv ----
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
// How it works
// (RULE1) Four one-hot phases from clk_sys form one instruction cycle.
// (RULE2) PC advances entering T1, and the new fetch is issued then.
// (RULE3) Decode and execute strobes are active during T2, T3 and T4.
// (RULE4) Fetch of the next instruction overlaps execution of the current.
// (RULE5) Branches take two cycles: target obtained, then dummy cycle while fetching.
// (RULE6) Without a branch the PC increments by one per instruction.
// (RULE7) Jump, call, interrupt and reset load a non-consecutive target.
// (RULE8) A taken skip discards the prefetched word and runs a dummy cycle.
// (RULE9) Software reaches only the low eight PC bits; the high bits can also be read over APB at FPC_OFS_PCH.
// (RULE10) The low byte register is readable and writable for program control.
// (RULE11) Writing the low byte jumps within the current 256-word page.
// (RULE12) Such a write inserts a dummy cycle to prefetch the new address.
// (RULE13) PC is 12 or 13 bits wide and clears to zero at reset.
module fpc_fetch_pc
	import fpc_pkg::*;
#(
	parameter int PC_W = FPC_PC_W_8K,
	parameter int PHASE_DIV = 1
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Program memory.
	output logic [PC_W-1:0] pmAddr,
	output logic pmRead,
	input wire logic [FPC_INSTR_W-1:0] pmData,
	// Decode and execute side, sampled during T4.
	input wire logic exJump,
	input wire logic [PC_W-1:0] exTarget,
	input wire logic exSkip,
	input wire logic exLowWr,
	input wire logic [FPC_LOW_W-1:0] exLowData,
	input wire logic intAck,
	input wire logic [PC_W-1:0] intVector,
	output logic [FPC_INSTR_W-1:0] execInstr,
	output logic execValid,
	output logic [FPC_PHASES-1:0] instrPhase,
	output logic [PC_W-1:0] pcValue
);

	// ---------------------------------------------------------------
	// Helpers.
	// ---------------------------------------------------------------
	function automatic logic [PC_W-1:0] pageJump(input logic [PC_W-1:0] pc, input logic [FPC_LOW_W-1:0] low);
		pageJump = {pc[PC_W-1:FPC_LOW_W], low};
	endfunction : pageJump

	// ---------------------------------------------------------------
	// State.
	// ---------------------------------------------------------------
	logic [PC_W-1:0] pc_r;
	logic [PC_W-1:0] pmAddr_r;
	logic pmRead_r;
	logic [FPC_INSTR_W-1:0] fetchBuf_r;
	logic [FPC_INSTR_W-1:0] execInstr_r;
	logic execValid_r;
	logic primed_r;
	logic runEn_r;
	logic swPend_r;
	logic [FPC_LOW_W-1:0] swLow_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [FPC_PHASES-1:0] phaseOh;
	logic phaseStep;

	fpc_phase_gen #(
		.PHASE_DIV(PHASE_DIV)
	) u_phase (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.runEn(runEn_r),
		.phaseOh_r(phaseOh),
		.phaseStep(phaseStep)
	);

	// ---------------------------------------------------------------
	// Sequencing decode.
	// ---------------------------------------------------------------
	wire enterT1 = phaseStep && (phaseOh == FPC_PHASE_T4);
	wire enterT2 = phaseStep && (phaseOh == FPC_PHASE_T1);
	// Jump, skip and low byte write count only from a real instruction; a dummy slot is ignored. Interrupt and software write redirect regardless.
	wire exLive = execValid_r;
	wire doInt = intAck;
	wire doJump = exLive && exJump;
	wire doExLow = exLive && exLowWr;
	wire doSwLow = swPend_r;
	wire doSkip = exLive && exSkip;
	wire redirect = doInt || doJump || doExLow || doSwLow;
	// (RULE7) Interrupt outranks jump, jump outranks a low byte write.
	wire [PC_W-1:0] loadPc = doInt ? intVector :
		doJump ? exTarget :
		// (RULE11) Low byte write keeps the page bits.
		doExLow ? pageJump(pc_r, exLowData) : pageJump(pc_r, swLow_r);
	wire [PC_W-1:0] fetchPc = redirect ? loadPc : pc_r;

	// ---------------------------------------------------------------
	// Program counter and fetch.
	// ---------------------------------------------------------------
	// The increment sits at the T1 edge so that the PC always names the next word.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			// (RULE13) Clear to the reset vector.
			pc_r <= '0;
			pmAddr_r <= '0;
			pmRead_r <= 1'b0;
		end else if (enterT1) begin
			// (RULE2) Advance and fetch in T1.
			pmAddr_r <= fetchPc;
			// (RULE6) Plain increment.
			pc_r <= fetchPc + PC_W'(1);
			pmRead_r <= 1'b1;
		end else begin
			pmRead_r <= 1'b0;
		end
	end

	// (RULE4) Fetched word lands while the previous one executes.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			fetchBuf_r <= '0;
		end else if (enterT2) begin
			fetchBuf_r <= pmData;
		end
	end

	// (RULE4) Right after reset nothing has been fetched, so the first slot is a dummy.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			primed_r <= 1'b0;
		end else if (enterT2) begin
			primed_r <= 1'b1;
		end
	end

	// (RULE5) Redirect or skip turns the prefetched word into a dummy.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			execInstr_r <= '0;
			execValid_r <= 1'b0;
		end else if (enterT1) begin
			execInstr_r <= fetchBuf_r;
			// (RULE8) Skip discards the prefetch.
			execValid_r <= primed_r && !(redirect || doSkip);
		end
	end

	// ---------------------------------------------------------------
	// APB slave.
	// ---------------------------------------------------------------
	wire apbSetup = psel && !penable && !pready_r;
	wire apbDone = psel && penable && pready_r;
	wire hitLow = (paddr == FPC_OFS_PC_LOW);
	wire hitPch = (paddr == FPC_OFS_PCH);
	wire hitCtrl = (paddr == FPC_OFS_CTRL);
	wire hitStat = (paddr == FPC_OFS_STAT);
	wire hitAny = hitLow || hitPch || hitCtrl || hitStat;
	// (RULE9) High bits are read only; a write there is refused.
	wire badAcc = !hitAny || (pwrite && (hitPch || hitStat));
	wire [31:0] statWord = {26'h000_0000, swPend_r, execValid_r, phaseOh};
	// (RULE10) Low byte reads back the live PC.
	wire [31:0] rdMux = hitLow ? {24'h00_0000, pc_r[FPC_LOW_W-1:0]} :
		hitPch ? 32'(pc_r[PC_W-1:FPC_LOW_W]) :
		hitCtrl ? {31'h0000_0000, runEn_r} :
		hitStat ? statWord : 32'h0000_0000;
	wire swWrLow = apbDone && pwrite && hitLow;

	// No wait state: the answer is prepared in setup and shown in the first access cycle.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= apbSetup;
			pslverr_r <= apbSetup && badAcc;
			prdata_r <= (apbSetup && !pwrite && !badAcc) ? rdMux : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			runEn_r <= FPC_CTRL_RST[FPC_CTRL_RUN];
		end else if (apbDone && pwrite && hitCtrl) begin
			runEn_r <= pwdata[FPC_CTRL_RUN];
		end
	end

	// (RULE12) A software write waits for the next T1 and then redirects.
	// A write in the same cycle as consumption wins and stays pending.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			swPend_r <= 1'b0;
			swLow_r <= '0;
		end else if (swWrLow) begin
			swPend_r <= 1'b1;
			swLow_r <= pwdata[FPC_LOW_W-1:0];
		end else if (enterT1) begin
			swPend_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Outputs.
	// ---------------------------------------------------------------
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pmAddr = pmAddr_r;
	assign pmRead = pmRead_r;
	assign execInstr = execInstr_r;
	assign execValid = execValid_r;
	// (RULE3) Execute side reads T2 to T4 from this.
	assign instrPhase = phaseOh;
	assign pcValue = pc_r;

	// ---------------------------------------------------------------
	// Checks.
	// ---------------------------------------------------------------
	sequence s_t1;
		enterT1;
	endsequence

	property p_fetch_inc;
		@(posedge clk_sys) disable iff (!rst_n) s_t1 |=> (pc_r == pmAddr_r + PC_W'(1)) && pmRead_r;
	endproperty
	a_fetch_inc: assert property (p_fetch_inc) else $error("fetch address or increment wrong"); // RULE2

	property p_seq;
		@(posedge clk_sys) disable iff (!rst_n) (s_t1 and !redirect) |=> pmAddr_r == $past(pc_r);
	endproperty
	a_seq: assert property (p_seq) else $error("sequential fetch skipped a word"); // RULE6

	property p_jump;
		@(posedge clk_sys) disable iff (!rst_n)
			(s_t1 and doJump and !doInt) |=> (pmAddr_r == $past(exTarget)) && !execValid_r;
	endproperty
	a_jump: assert property (p_jump) else $error("jump did not load target with dummy"); // RULE5

	property p_int;
		@(posedge clk_sys) disable iff (!rst_n) (s_t1 and doInt) |=> pmAddr_r == $past(intVector);
	endproperty
	a_int: assert property (p_int) else $error("interrupt vector not loaded"); // RULE7

	property p_skip;
		@(posedge clk_sys) disable iff (!rst_n) (s_t1 and doSkip) |=> !execValid_r;
	endproperty
	a_skip: assert property (p_skip) else $error("skip did not discard prefetch"); // RULE8

	property p_page;
		@(posedge clk_sys) disable iff (!rst_n) (s_t1 and doSwLow and !doInt and !doJump and !doExLow)
			|=> pmAddr_r[PC_W-1:FPC_LOW_W] == $past(pc_r[PC_W-1:FPC_LOW_W]) && !execValid_r;
	endproperty
	a_page: assert property (p_page) else $error("low byte jump left its page"); // RULE11

	property p_sw_pend;
		@(posedge clk_sys) disable iff (!rst_n) swWrLow |=> swPend_r && swLow_r == $past(pwdata[FPC_LOW_W-1:0]);
	endproperty
	a_sw_pend: assert property (p_sw_pend) else $error("low byte write lost"); // RULE12

	property p_exec_hold;
		@(posedge clk_sys) disable iff (!rst_n) !enterT1 |=> $stable(execInstr_r) && $stable(execValid_r);
	endproperty
	a_exec_hold: assert property (p_exec_hold) else $error("execute slot changed outside T1"); // RULE4

	property p_pch_ro;
		@(posedge clk_sys) disable iff (!rst_n) (apbSetup && pwrite && hitPch) |=> pslverr_r && pready_r;
	endproperty
	a_pch_ro: assert property (p_pch_ro) else $error("write to high bits not refused"); // RULE9

	property p_reset;
		@(posedge clk_sys) !rst_n |=> pc_r == '0 && !execValid_r;
	endproperty
	a_reset: assert property (p_reset) else $error("reset did not clear PC"); // RULE13

	property p_ready_pulse;
		@(posedge clk_sys) disable iff (!rst_n) pready_r |=> !pready_r;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held past one access cycle"); // RULE10

	property p_freeze;
		@(posedge clk_sys) disable iff (!rst_n) !runEn_r |=> $stable(phaseOh);
	endproperty
	a_freeze: assert property (p_freeze) else $error("phases moved while stopped"); // RULE1

	property p_sw_apply;
		@(posedge clk_sys) disable iff (!rst_n) (s_t1 and doSwLow and !doInt and !doJump and !doExLow)
			|=> pmAddr_r[FPC_LOW_W-1:0] == $past(swLow_r);
	endproperty
	a_sw_apply: assert property (p_sw_apply) else $error("queued low byte not applied"); // RULE12

	property p_int_dummy;
		@(posedge clk_sys) disable iff (!rst_n) (s_t1 and doInt) |=> !execValid_r;
	endproperty
	a_int_dummy: assert property (p_int_dummy) else $error("interrupt entry without dummy slot"); // RULE7

endmodule : fpc_fetch_pc

// ---- rtl/fpc_phase_gen.sv ----
`timescale 1ns/1ps
module fpc_phase_gen
	import fpc_pkg::*;
#(
	parameter int PHASE_DIV = 1
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Control.
	input wire logic runEn,
	// Phase outputs.
	output logic [FPC_PHASES-1:0] phaseOh_r,
	output logic phaseStep
);

	// ---------------------------------------------------------------
	// Divider: one step pulse every PHASE_DIV clocks.
	// ---------------------------------------------------------------
	logic [15:0] divCnt_r;
	logic divLast;

	assign divLast = (divCnt_r == 16'(PHASE_DIV - 1));
	assign phaseStep = runEn && divLast;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			divCnt_r <= 16'h0000;
		end else if (!runEn || divLast) begin
			divCnt_r <= 16'h0000;
		end else begin
			divCnt_r <= divCnt_r + 16'h0001;
		end
	end

	// ---------------------------------------------------------------
	// Phase ring.
	// ---------------------------------------------------------------
	// Reset parks in T4 so that the first step enters T1 and fetches the vector.
	// (RULE1) Non-overlapping one-hot phases.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			phaseOh_r <= FPC_PHASE_T4;
		end else if (phaseStep) begin
			phaseOh_r <= {phaseOh_r[FPC_PHASES-2:0], phaseOh_r[FPC_PHASES-1]};
		end
	end

	// (RULE1) Phases never overlap.
	property p_phase_onehot;
		@(posedge clk_sys) disable iff (!rst_n) $onehot(phaseOh_r);
	endproperty
	a_phase_onehot: assert property (p_phase_onehot) else $error("phase clocks overlap"); // RULE1

endmodule : fpc_phase_gen

// ---- rtl/fpc_pkg.sv ----
package fpc_pkg;

	// ---------------------------------------------------------------
	// Register map.
	// ---------------------------------------------------------------
	localparam logic [11:0] FPC_OFS_PC_LOW = 12'h000;
	localparam logic [11:0] FPC_OFS_PCH = 12'h004;
	localparam logic [11:0] FPC_OFS_CTRL = 12'h008;
	localparam logic [11:0] FPC_OFS_STAT = 12'h00C;

	// ---------------------------------------------------------------
	// Fields, widths and reset values.
	// ---------------------------------------------------------------
	localparam int FPC_PHASES = 4;
	localparam int FPC_LOW_W = 8;
	localparam int FPC_PC_W_8K = 13;
	localparam int FPC_INSTR_W = 16;
	localparam int FPC_CTRL_RUN = 0;
	localparam logic [31:0] FPC_CTRL_RST = 32'h0000_0001;
	localparam int FPC_STAT_VALID = 4;
	localparam int FPC_STAT_PEND = 5;
	localparam logic [3:0] FPC_PHASE_T1 = 4'h1;
	localparam logic [3:0] FPC_PHASE_T4 = 4'h8;

endpackage : fpc_pkg

// ---- verification/fpc_pm_model.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Program memory model.
// ---------------------------------------------------------------
module fpc_pm_model
	import fpc_pkg::*;
#(
	parameter int PC_W = FPC_PC_W_8K
) (
	// Clock.
	input wire logic clk_sys,
	// Fetch side.
	input wire logic [PC_W-1:0] pmAddr,
	input wire logic pmRead,
	output logic [FPC_INSTR_W-1:0] pmData
);
	logic [PC_W-1:0] addr_r;
	logic hold_r;
	logic [FPC_INSTR_W-1:0] heldWord;

	assign heldWord = 16'hA000 | 16'(addr_r);
	always_ff @(posedge clk_sys) begin
		hold_r <= pmRead;
		if (pmRead) begin
			addr_r <= pmAddr;
		end
	end
	// Past its window the word is inverted, so a late sample cannot match by luck.
	assign pmData = pmRead ? (16'hA000 | 16'(pmAddr)) : (hold_r ? heldWord : ~heldWord);
endmodule : fpc_pm_model

// ---- verification/tb_fetch_pipeline_program_counter.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Testbench.
// ---------------------------------------------------------------
module tb_fetch_pipeline_program_counter;
	import fpc_pkg::*;
	logic clk_sys, rst_n, psel, penable, pwrite, exJump, exSkip, exLowWr, intAck;
	logic pready, pslverr, pmRead, execValid, errV;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdV;
	logic [12:0] pmAddr, exTarget, intVector, pcValue, expPc;
	logic [15:0] pmData, execInstr, lastWord;
	logic [7:0] exLowData;
	logic [3:0] instrPhase;
	int numErrors = 0;
	int nCompared = 0;

	fpc_fetch_pc #(.PC_W(13), .PHASE_DIV(1)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pmAddr(pmAddr), .pmRead(pmRead), .pmData(pmData),
		.exJump(exJump), .exTarget(exTarget), .exSkip(exSkip), .exLowWr(exLowWr),
		.exLowData(exLowData), .intAck(intAck), .intVector(intVector), .execInstr(execInstr),
		.execValid(execValid), .instrPhase(instrPhase), .pcValue(pcValue));
	fpc_pm_model #(.PC_W(13)) mem (.clk_sys(clk_sys), .pmAddr(pmAddr), .pmRead(pmRead), .pmData(pmData));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			numErrors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("Compared %0d, errors %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop

	// Core requests are raised for the whole of T4; arriving already in T4 means a plain step.
	task automatic issue(input logic j, s, w, i, input logic [12:0] t, input logic [7:0] d);
		int n;
		n = 0;
		while (instrPhase !== FPC_PHASE_T4 && instrPhase !== 4'h4 && n < 20) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (instrPhase === 4'h4) begin
			@(posedge clk_sys);
			{exJump, exSkip, exLowWr, intAck} <= {j, s, w, i};
			{exTarget, intVector, exLowData} <= {t, t, d};
		end
		@(posedge clk_sys);
		{exJump, exSkip, exLowWr, intAck} <= 4'h0;
		#1;
	endtask : issue

	task automatic fetchChk(input logic dm, input logic [12:0] a);
		chk("pmAddr", pmAddr, a);
		chk("pcValue", pcValue, a + 13'h1);
		chk("pmRead", pmRead, 1'b1);
		chk("execValid", execValid, !dm);
		if (!dm) begin
			chk("execInstr", execInstr, lastWord);
		end
		lastWord = 16'hA000 | 16'(a);
		expPc = a + 13'h1;
	endtask : fetchChk

	// One APB transfer in T2..T3, then a plain step to the next T1.
	task automatic apbChk(input logic w, input logic [11:0] a, input logic [31:0] wd, ex, input logic er);
		int n;
		n = 0;
		@(posedge clk_sys);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
		@(posedge clk_sys);
		penable <= 1'b1;
		#1;
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		rdV = prdata;
		errV = pslverr;
		@(posedge clk_sys);
		{psel, penable} <= 2'b00;
		#1;
		chk("pready", {31'h0000_0000, n < 20}, 32'h0000_0001);
		chk("pslverr", errV, er);
		if (!w) begin
			chk("prdata", rdV, ex);
		end
		issue(0, 0, 0, 0, '0, '0);
	endtask : apbChk

	initial begin
		{rst_n, psel, penable, pwrite, exJump, exSkip, exLowWr, intAck} = '0;
		{paddr, pwdata, exTarget, intVector, exLowData} = '0;
		repeat (10) @(posedge clk_sys);
		#1;
		chk("pcValue", pcValue, 0);
		chk("instrPhase", instrPhase, FPC_PHASE_T4);
		@(posedge clk_sys);
		rst_n <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_sys);
			#1;
			chk("instrPhase", instrPhase, 32'(1 << k));
		end
		lastWord = 16'hA000;
		expPc = 13'h0001;
		repeat (3) begin
			issue(0, 0, 0, 0, '0, '0);
			fetchChk(0, expPc);
		end
		issue(1, 0, 0, 0, 13'h01FE, '0);
		fetchChk(1, 13'h01FE);
		repeat (3) begin
			issue(0, 0, 0, 0, '0, '0);
			fetchChk(0, expPc);
		end
		issue(0, 1, 0, 0, '0, '0);
		fetchChk(1, expPc);
		issue(0, 0, 0, 0, '0, '0);
		fetchChk(0, expPc);
		issue(0, 0, 1, 0, '0, 8'h35);
		fetchChk(1, {expPc[12:8], 8'h35});
		issue(0, 0, 0, 0, '0, '0);
		fetchChk(0, expPc);
		apbChk(0, FPC_OFS_PC_LOW, '0, 32'(expPc[7:0]), 0);
		fetchChk(0, expPc);
		apbChk(0, FPC_OFS_PCH, '0, 32'(expPc[12:8]), 0);
		fetchChk(0, expPc);
		apbChk(1, FPC_OFS_PCH, 32'h0000_001F, '0, 1);
		fetchChk(0, expPc);
		apbChk(0, 12'h010, '0, '0, 1);
		fetchChk(0, expPc);
		apbChk(0, FPC_OFS_CTRL, '0, FPC_CTRL_RST, 0);
		fetchChk(0, expPc);
		apbChk(1, FPC_OFS_PC_LOW, 32'h0000_0080, '0, 0);
		fetchChk(1, {expPc[12:8], 8'h80});
		issue(0, 0, 0, 0, '0, '0);
		fetchChk(0, expPc);
		issue(0, 0, 0, 1, 13'h0004, '0);
		fetchChk(1, 13'h0004);
		issue(0, 0, 0, 0, '0, '0);
		fetchChk(0, expPc);
		apbChk(1, FPC_OFS_CTRL, 32'h0000_0000, '0, 0);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("instrPhase", instrPhase, FPC_PHASE_T4);
		apbChk(1, FPC_OFS_CTRL, FPC_CTRL_RST, '0, 0);
		fetchChk(0, expPc);
		report_and_stop();
	end

	// The whole sequence needs about a hundred cycles; this bounds a hang.
	initial begin
		#50000;
		numErrors++;
		report_and_stop();
	end
endmodule : tb_fetch_pipeline_program_counter
